// [design/reader_status_consts.svh]
// register offsets, field positions, reset values and sizes of the reader status bank
// assumes: included by bare name from the design modules and the bench
`ifndef READER_STATUS_CONSTS_SVH
`define READER_STATUS_CONSTS_SVH

// register offsets on the host register port
`define REG_STATUS_ONE 6'h07
`define REG_STATUS_TWO 6'h08
`define REG_FIFO_DATA 6'h09
`define REG_FIFO_LEVEL 6'h0a
`define REG_WARN_LEVEL 6'h0b
`define REG_BIT_FRAME 6'h0d

// reset values
`define STATUS_ONE_RESET 8'h21
`define STATUS_TWO_RESET 8'h00
`define WARN_LEVEL_RESET 6'h08

// fifo size in bytes
`define FIFO_DEPTH 7'h40

// first status register fields
`define S1_CRC_ZERO 6
`define S1_CRC_DONE 5
`define S1_IRQ 4
`define S1_TIMER 3
`define S1_NEAR_FULL 1
`define S1_NEAR_EMPTY 0

// second status register fields
`define S2_OVERHEAT_CLEAR 7
`define S2_FORCE_FAST 6
`define S2_CIPHER 3

// write-only strobes in neighbouring registers
`define FLUSH_BIT 7
`define BEGIN_TX_BIT 7

`endif

// [design/reader_status_pkg.sv]
// types shared by the reader status bank
// assumes: nothing beyond the constants header
package reader_status_pkg;

	// transmit/receive sequencer states, codes as reported to software
	typedef enum logic [2:0] {
		LINK_IDLE = 3'b000,
		LINK_WAIT_BEGIN = 3'b001,
		LINK_TX_WAIT = 3'b010,
		LINK_TRANSMIT = 3'b011,
		LINK_RX_WAIT = 3'b100,
		LINK_WAIT_DATA = 3'b101,
		LINK_RECEIVE = 3'b110
	} link_state_e;

	// one host register access
	typedef struct packed {
		logic [5:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} host_req_s;

	// live status of the surrounding engines
	typedef struct packed {
		logic checksum_running;
		logic checksum_zero;
		logic [7:0] main_irq_pending;
		logic [7:0] main_irq_enable;
		logic [7:0] misc_irq_pending;
		logic [7:0] misc_irq_enable;
		logic timer_counting;
		logic timer_started;
		logic [1:0] timer_gate_select;
		logic temp_below_limit;
		logic auth_success;
	} engine_status_s;

	// controls and events of the radio link
	typedef struct packed {
		logic transceive_active;
		logic wait_for_field;
		logic rf_field_present;
		logic [7:0] tx_wait_cycles;
		logic [7:0] rx_wait_cycles;
		logic tx_done;
		logic rx_start;
		logic rx_done;
	} link_status_s;

endpackage

// [design/fifo_level_tracker.sv]
// fifo byte count and warning threshold register
// assumes: data port strobes are single-cycle, one access per cycle
`timescale 1ns/100ps
`include "reader_status_consts.svh"

module fifo_level_tracker
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic data_write,
	input wire logic data_read,
	input wire logic flush,
	input wire logic thr_write,
	input wire logic [5:0] thr_wdata,
	output logic [6:0] byte_count,
	output logic [5:0] warn_threshold
);

	logic [6:0] count_reg;
	logic [6:0] count_next;
	logic [5:0] thr_reg;
	logic [5:0] thr_next;

	// count moves with data port accesses, saturating at empty and full
	always_comb
	begin
		count_next = count_reg;
		if (flush)
			count_next = 7'h00;
		else if (data_write && !data_read && count_reg != `FIFO_DEPTH)
			count_next = count_reg + 7'h01;
		else if (data_read && !data_write && count_reg != 7'h00)
			count_next = count_reg - 7'h01;
		thr_next = thr_write ? thr_wdata : thr_reg;
	end

	// register count and threshold
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count_reg <= 7'h00;
			thr_reg <= `WARN_LEVEL_RESET;
		end
		else
		begin
			count_reg <= count_next;
			thr_reg <= thr_next;
		end
	end

	assign byte_count = count_reg;
	assign warn_threshold = thr_reg;

endmodule

// [design/reader_status_registers.sv]
// reader status bank: two status registers, fifo alerts and the link sequencer
// assumes: host port accesses are single-cycle strobes; engine inputs synchronous to sys_clk
//
// Contract
// - bit 6 of status one: low while checksum runs, high when done with zero result
// - checksum-zero is undefined during transmit and receive; hold its last value then
// - bit 5 of status one reports checksum finished, meaningful for the checksum command
// - bit 4 is high when any interrupt source is pending with its enable set
// - bit 3 is high while the timer unit is counting
// - in gated mode the timer flag follows the gate select, not the gate level
// - bit 1 high when 64 minus fifo count is at most the threshold
// - bit 0 high when fifo count is at most the threshold
// - status one resets to 0x21, status two to 0x00
// - writing 1 to status two bit 7 clears overheat only below the alarm limit
// - status two bit 6 forces the fast input filter when set
// - status two bit 3 shows the stream cipher is active
// - cipher flag set only by successful authentication; software clears it
// - bits 2 to 0 encode the link sequencer state
// - state 010 is transmit wait, minimum from tx wait time, optional field wait
// - state 100 is receive wait, minimum from rx wait time, optional field wait
// - begin-transmit launches transmission only while transceive is active
// - fifo warning threshold is a 6-bit read/write register reset to 0x08
// - fifo count increments on data writes and decrements on data reads
`timescale 1ns/100ps
`include "reader_status_consts.svh"

module reader_status_registers
	import reader_status_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire host_req_s host_req,
	input wire engine_status_s engine,
	input wire link_status_s link,
	output logic [7:0] reg_rdata,
	output logic overheat_clear_pulse,
	output logic force_fast_input_filter,
	output logic cipher_active,
	output logic [2:0] link_fsm_state,
	output logic tx_enable,
	output logic rx_enable
);

	logic [7:0] status_one_reg;
	logic [7:0] status_one_next;
	logic overheat_clear_reg;
	logic overheat_clear_next;
	logic force_fast_reg;
	logic force_fast_next;
	logic cipher_reg;
	logic cipher_next;
	logic clear_pulse_reg;
	logic clear_pulse_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	link_state_e state_reg;
	link_state_e state_next;
	logic [7:0] wait_cnt_reg;
	logic [7:0] wait_cnt_next;
	logic tx_en_reg;
	logic tx_en_next;
	logic rx_en_reg;
	logic rx_en_next;
	logic [6:0] byte_count;
	logic [5:0] warn_threshold;
	logic wr_status_two;
	logic data_write;
	logic data_read;
	logic begin_transmit;
	logic link_busy;
	logic near_full;
	logic near_empty;
	logic irq_any;
	logic timer_active;
	logic tx_wait_over;
	logic rx_wait_over;
	logic [7:0] status_two_view;

	// host port decode
	assign wr_status_two = host_req.wr && host_req.addr == `REG_STATUS_TWO;
	assign data_write = host_req.wr && host_req.addr == `REG_FIFO_DATA;
	assign data_read = host_req.rd && host_req.addr == `REG_FIFO_DATA;
	assign begin_transmit = host_req.wr && host_req.addr == `REG_BIT_FRAME
		&& host_req.wdata[`BEGIN_TX_BIT];

	// fifo count and warning threshold
	fifo_level_tracker u_level
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.data_write(data_write),
		.data_read(data_read),
		.flush(host_req.wr && host_req.addr == `REG_FIFO_LEVEL
			&& host_req.wdata[`FLUSH_BIT]),
		.thr_write(host_req.wr && host_req.addr == `REG_WARN_LEVEL),
		.thr_wdata(host_req.wdata[5:0]),
		.byte_count(byte_count),
		.warn_threshold(warn_threshold)
	);

	// live conditions feeding status one
	assign near_full = (`FIFO_DEPTH - byte_count) <= {1'b0, warn_threshold};
	assign near_empty = byte_count <= {1'b0, warn_threshold};
	assign irq_any = |(engine.main_irq_pending & engine.main_irq_enable)
		| |(engine.misc_irq_pending & engine.misc_irq_enable);
	assign timer_active = (engine.timer_gate_select != 2'b00) ? engine.timer_started
		: engine.timer_counting;
	assign link_busy = state_reg == LINK_TRANSMIT || state_reg == LINK_RECEIVE;

	// status one is rebuilt from its sources every cycle, except bit 6, which holds during transmit and receive; reserved bits stay zero
	always_comb
	begin
		status_one_next = 8'h00;
		status_one_next[`S1_CRC_ZERO] = link_busy ? status_one_reg[`S1_CRC_ZERO]
			: (!engine.checksum_running && engine.checksum_zero);
		status_one_next[`S1_CRC_DONE] = !engine.checksum_running;
		status_one_next[`S1_IRQ] = irq_any;
		status_one_next[`S1_TIMER] = timer_active;
		status_one_next[`S1_NEAR_FULL] = near_full;
		status_one_next[`S1_NEAR_EMPTY] = near_empty;
	end

	// status one register
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			status_one_reg <= `STATUS_ONE_RESET;
		else
			status_one_reg <= status_one_next;
	end

	// writable and event-set bits of status two
	always_comb
	begin
		overheat_clear_next = overheat_clear_reg;
		force_fast_next = force_fast_reg;
		cipher_next = cipher_reg;
		clear_pulse_next = 1'b0;
		if (wr_status_two)
		begin
			overheat_clear_next = host_req.wdata[`S2_OVERHEAT_CLEAR];
			force_fast_next = host_req.wdata[`S2_FORCE_FAST];
			if (!host_req.wdata[`S2_CIPHER])
				cipher_next = 1'b0;
			clear_pulse_next = host_req.wdata[`S2_OVERHEAT_CLEAR]
				&& engine.temp_below_limit;
		end
		// authentication success wins over a same-cycle software clear
		if (engine.auth_success)
			cipher_next = 1'b1;
	end

	// status two control register
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			overheat_clear_reg <= 1'b0;
			force_fast_reg <= 1'b0;
			cipher_reg <= 1'b0;
			clear_pulse_reg <= 1'b0;
		end
		else
		begin
			overheat_clear_reg <= overheat_clear_next;
			force_fast_reg <= force_fast_next;
			cipher_reg <= cipher_next;
			clear_pulse_reg <= clear_pulse_next;
		end
	end

	// minimum wait and optional field wait for both wait phases
	assign tx_wait_over = wait_cnt_reg >= link.tx_wait_cycles
		&& (!link.wait_for_field || link.rf_field_present);
	assign rx_wait_over = wait_cnt_reg >= link.rx_wait_cycles
		&& (!link.wait_for_field || link.rf_field_present);

	// link sequencer next state
	always_comb
	begin
		state_next = state_reg;
		wait_cnt_next = (wait_cnt_reg == 8'hff) ? wait_cnt_reg : wait_cnt_reg + 8'h01;
		case (state_reg)
			LINK_IDLE:
				if (link.transceive_active)
					state_next = LINK_WAIT_BEGIN;
			LINK_WAIT_BEGIN:
				if (begin_transmit)
					state_next = LINK_TX_WAIT;
			LINK_TX_WAIT:
				if (tx_wait_over)
					state_next = LINK_TRANSMIT;
			LINK_TRANSMIT:
				if (link.tx_done)
					state_next = LINK_RX_WAIT;
			LINK_RX_WAIT:
				if (rx_wait_over)
					state_next = LINK_WAIT_DATA;
			LINK_WAIT_DATA:
				if (link.rx_start)
					state_next = LINK_RECEIVE;
			LINK_RECEIVE:
				if (link.rx_done)
					state_next = LINK_WAIT_BEGIN;
			default:
				state_next = LINK_IDLE;
		endcase
		// leaving the transceive command drops the sequencer back to idle
		if (!link.transceive_active)
			state_next = LINK_IDLE;
		if (state_next != state_reg)
			wait_cnt_next = 8'h00;
		// enables registered alongside the state so they leave a flop
		tx_en_next = state_next == LINK_TRANSMIT;
		rx_en_next = state_next == LINK_RECEIVE;
	end

	// link sequencer registers
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_reg <= LINK_IDLE;
			wait_cnt_reg <= 8'h00;
			tx_en_reg <= 1'b0;
			rx_en_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			wait_cnt_reg <= wait_cnt_next;
			tx_en_reg <= tx_en_next;
			rx_en_reg <= rx_en_next;
		end
	end

	// status two as software sees it
	assign status_two_view = {overheat_clear_reg, force_fast_reg, 2'b00, cipher_reg,
		state_reg};

	// registered read data; unmapped offsets read zero
	always_comb
	begin
		rdata_next = 8'h00;
		if (host_req.rd)
			case (host_req.addr)
				`REG_STATUS_ONE: rdata_next = status_one_reg;
				`REG_STATUS_TWO: rdata_next = status_two_view;
				`REG_FIFO_LEVEL: rdata_next = {1'b0, byte_count};
				`REG_WARN_LEVEL: rdata_next = {2'b00, warn_threshold};
				default: rdata_next = 8'h00;
			endcase
	end

	// read data register
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end

	// outputs straight from flops
	assign reg_rdata = rdata_reg;
	assign overheat_clear_pulse = clear_pulse_reg;
	assign force_fast_input_filter = force_fast_reg;
	assign cipher_active = cipher_reg;
	assign link_fsm_state = state_reg;
	assign tx_enable = tx_en_reg;
	assign rx_enable = rx_en_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// checks
	a_crc_zero_busy: assert property (
		engine.checksum_running && !link_busy |=> !status_one_reg[`S1_CRC_ZERO])
		else $error("checksum zero flag high while checksum runs");

	a_crc_done_flag: assert property (
		##1 status_one_reg[`S1_CRC_DONE] == !$past(engine.checksum_running))
		else $error("checksum done flag does not track the engine");

	a_irq_combined: assert property (
		##1 status_one_reg[`S1_IRQ] == $past(irq_any))
		else $error("interrupt flag missing for enabled pending source");

	a_timer_gated: assert property (
		engine.timer_gate_select != 2'b00 && engine.timer_started
		|=> status_one_reg[`S1_TIMER])
		else $error("gated timer flag not following gate select");

	a_near_full_cmp: assert property (
		##1 status_one_reg[`S1_NEAR_FULL]
		== $past((`FIFO_DEPTH - byte_count) <= {1'b0, warn_threshold}))
		else $error("near full flag disagrees with fifo count");

	a_near_empty_cmp: assert property (
		##1 status_one_reg[`S1_NEAR_EMPTY] == $past(byte_count <= {1'b0, warn_threshold}))
		else $error("near empty flag disagrees with fifo count");

	a_overheat_gate: assert property (
		overheat_clear_pulse |-> $past(wr_status_two && engine.temp_below_limit))
		else $error("overheat clear issued without write or when hot");

	a_cipher_set: assert property (
		$rose(cipher_active) |-> $past(engine.auth_success))
		else $error("cipher flag rose without authentication");

	a_begin_gated: assert property (
		state_reg == LINK_WAIT_BEGIN && !begin_transmit |=> state_reg != LINK_TX_WAIT)
		else $error("transmission started without begin-transmit");

	a_reserved_zero: assert property (
		status_one_reg[7] == 1'b0 && status_one_reg[2] == 1'b0)
		else $error("reserved status bits not zero");

endmodule

// [dv/reader_status_registers_tb_top.sv]
// self-checking bench for the reader status bank
// assumes: design package and constants header compiled first, assertions live in the design
`timescale 1ns/100ps
`include "reader_status_consts.svh"

module reader_status_registers_tb_top;
	import reader_status_pkg::*;

	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	host_req_s req = '0;
	engine_status_s eng = '0;
	link_status_s lnk = '0;
	logic [7:0] reg_rdata;
	logic overheat_clear_pulse;
	logic force_fast_input_filter;
	logic cipher_active;
	logic [2:0] link_fsm_state;
	logic tx_enable;
	logic rx_enable;
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	int cnt = 0;
	int n;
	logic [5:0] thr = 6'h08;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;

	// 250 MHz clock
	always #2 sys_clk = ~sys_clk;

	reader_status_registers dut_u (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.host_req(req),
		.engine(eng),
		.link(lnk),
		.reg_rdata(reg_rdata),
		.overheat_clear_pulse(overheat_clear_pulse),
		.force_fast_input_filter(force_fast_input_filter),
		.cipher_active(cipher_active),
		.link_fsm_state(link_fsm_state),
		.tx_enable(tx_enable),
		.rx_enable(rx_enable)
	);

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
		num_checks++;
		if (seen !== expv)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, expv, seen);
		end
	endtask

	task automatic summarize();
		$display("mismatches %0d of %0d checks", err_total, num_checks);
		if (err_total == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// expected status one from the live sources and the tracked fifo count
	function automatic logic [7:0] s1();
		logic [7:0] v;
		v = 8'h00;
		v[6] = !eng.checksum_running & eng.checksum_zero;
		v[5] = !eng.checksum_running;
		v[4] = |(eng.main_irq_pending & eng.main_irq_enable) |
			|(eng.misc_irq_pending & eng.misc_irq_enable);
		v[3] = (eng.timer_gate_select != 2'b00) ? eng.timer_started : eng.timer_counting;
		v[1] = (64 - cnt) <= int'(thr);
		v[0] = cnt <= int'(thr);
		return v;
	endfunction

	// one access: strobe for one edge, then idle, ending on a falling edge
	task automatic access(input logic [5:0] a, input logic w, input logic r, input logic [7:0] d);
		@(negedge sys_clk);
		req.addr = a;
		req.wr = w;
		req.rd = r;
		req.wdata = d;
		@(negedge sys_clk);
		req.wr = 1'b0;
		req.rd = 1'b0;
	endtask

	task automatic wreg(input logic [5:0] a, input logic [7:0] d);
		access(a, 1'b1, 1'b0, d);
	endtask

	task automatic rreg(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		access(a, 1'b0, 1'b1, 8'h00);
	endtask

	// wait a bounded number of cycles for a sequencer state, then compare
	task automatic wait_st(input logic [2:0] e, input int mx, output int k);
		k = 0;
		while (link_fsm_state !== e && k < mx)
		begin
			@(negedge sys_clk);
			k++;
		end
		check("link state", {5'h00, link_fsm_state}, {5'h00, e});
	endtask

	task automatic pulse_tx();
		@(negedge sys_clk);
		lnk.tx_done = 1'b1;
		@(negedge sys_clk);
		lnk.tx_done = 1'b0;
	endtask

	// read data monitor: takes the oldest expected value per answered read
	always @(posedge sys_clk) rd_seen <= req.rd;
	always @(negedge sys_clk)
	begin
		if (rd_seen)
		begin
			if (exp_q.size() == 0)
				check("unexpected read", 8'h01, 8'h00);
			else
				check("reg_rdata", reg_rdata, exp_q.pop_front());
		end
	end

	// hang guard
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			summarize();
		end
	end

	// main sequence
	initial
	begin
		void'($urandom(32'h973a));
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		rreg(`REG_STATUS_ONE, 8'h21);
		rreg(`REG_STATUS_TWO, 8'h00);
		rreg(`REG_WARN_LEVEL, 8'h08);
		// random engine status, link idle
		repeat (30)
		begin
			eng.main_irq_pending = 8'($urandom);
			eng.main_irq_enable = 8'($urandom);
			eng.misc_irq_pending = 8'($urandom) & 8'($urandom);
			eng.misc_irq_enable = 8'($urandom) & 8'($urandom);
			eng.timer_gate_select = 2'($urandom);
			eng.timer_counting = 1'($urandom);
			eng.timer_started = 1'($urandom);
			eng.checksum_running = 1'($urandom);
			eng.checksum_zero = 1'($urandom);
			rreg(`REG_STATUS_ONE, s1());
		end
		// fifo alerts across every count with threshold 4
		wreg(`REG_WARN_LEVEL, 8'hc4);
		thr = 6'h04;
		rreg(`REG_WARN_LEVEL, 8'h04);
		wreg(`REG_FIFO_LEVEL, 8'h80);
		for (int i = 0; i < 66; i++)
		begin
			rreg(`REG_FIFO_LEVEL, 8'(cnt));
			rreg(`REG_STATUS_ONE, s1());
			wreg(`REG_FIFO_DATA, 8'($urandom));
			cnt = (cnt < 64) ? cnt + 1 : 64;
		end
		repeat (3)
		begin
			rreg(`REG_FIFO_DATA, 8'h00);
			cnt--;
			rreg(`REG_FIFO_LEVEL, 8'(cnt));
		end
		thr = 6'($urandom);
		wreg(`REG_WARN_LEVEL, {2'b11, thr});
		rreg(`REG_WARN_LEVEL, {2'b00, thr});
		rreg(`REG_STATUS_ONE, s1());
		rreg(6'h3f, 8'h00);
		wreg(`REG_STATUS_ONE, 8'hff);
		rreg(`REG_STATUS_ONE, s1());
		// overheat clear and input filter control
		eng.temp_below_limit = 1'b1;
		wreg(`REG_STATUS_TWO, 8'hf8);
		check("overheat pulse", {7'h00, overheat_clear_pulse}, 8'h01);
		check("fast filter", {7'h00, force_fast_input_filter}, 8'h01);
		@(negedge sys_clk);
		check("overheat pulse end", {7'h00, overheat_clear_pulse}, 8'h00);
		rreg(`REG_STATUS_TWO, 8'hc0);
		eng.temp_below_limit = 1'b0;
		wreg(`REG_STATUS_TWO, 8'h80);
		check("overheat blocked", {7'h00, overheat_clear_pulse}, 8'h00);
		check("fast filter off", {7'h00, force_fast_input_filter}, 8'h00);
		rreg(`REG_STATUS_TWO, 8'h80);
		// cipher flag set by authentication, cleared by software
		@(negedge sys_clk);
		eng.auth_success = 1'b1;
		@(negedge sys_clk);
		eng.auth_success = 1'b0;
		check("cipher set", {7'h00, cipher_active}, 8'h01);
		rreg(`REG_STATUS_TWO, 8'h88);
		wreg(`REG_STATUS_TWO, 8'h08);
		check("cipher kept", {7'h00, cipher_active}, 8'h01);
		wreg(`REG_STATUS_TWO, 8'h00);
		check("cipher cleared", {7'h00, cipher_active}, 8'h00);
		// link sequencer, first round waits for the field
		eng.checksum_running = 1'b0;
		lnk.tx_wait_cycles = 8'h03;
		lnk.rx_wait_cycles = 8'h05;
		lnk.wait_for_field = 1'b1;
		@(negedge sys_clk);
		lnk.transceive_active = 1'b1;
		wait_st(3'b001, 4, n);
		wreg(`REG_BIT_FRAME, 8'h80);
		wait_st(3'b010, 3, n);
		repeat (10) @(negedge sys_clk);
		wait_st(3'b010, 0, n);
		lnk.rf_field_present = 1'b1;
		wait_st(3'b011, 8, n);
		check("tx enable", {7'h00, tx_enable}, 8'h01);
		rreg(`REG_STATUS_TWO, 8'h03);
		pulse_tx();
		wait_st(3'b100, 3, n);
		wait_st(3'b101, 12, n);
		check("rx wait length", 8'(n >= 5), 8'h01);
		@(negedge sys_clk);
		lnk.rx_start = 1'b1;
		@(negedge sys_clk);
		lnk.rx_start = 1'b0;
		wait_st(3'b110, 3, n);
		check("rx enable", {7'h00, rx_enable}, 8'h01);
		rreg(`REG_STATUS_TWO, 8'h06);
		@(negedge sys_clk);
		lnk.rx_done = 1'b1;
		@(negedge sys_clk);
		lnk.rx_done = 1'b0;
		wait_st(3'b001, 3, n);
		// second round, field wait option off and no field: minimum transmit wait only
		lnk.wait_for_field = 1'b0;
		lnk.rf_field_present = 1'b0;
		wreg(`REG_BIT_FRAME, 8'h80);
		wait_st(3'b010, 3, n);
		wait_st(3'b011, 12, n);
		check("tx wait length", 8'(n >= 3), 8'h01);
		// abort, then begin-transmit without transceive is ignored
		lnk.transceive_active = 1'b0;
		wait_st(3'b000, 3, n);
		wreg(`REG_BIT_FRAME, 8'h80);
		repeat (4) @(negedge sys_clk);
		wait_st(3'b000, 0, n);
		check("tx idle", {7'h00, tx_enable}, 8'h00);
		rreg(`REG_STATUS_TWO, 8'h00);
		// mid-run reset brings back the status two, warning level and fifo count reset values; status one is checked live
		wreg(`REG_STATUS_TWO, 8'hc0);
		wreg(`REG_WARN_LEVEL, 8'h3f);
		wreg(`REG_FIFO_DATA, 8'h55);
		@(negedge sys_clk);
		sys_rst = 1'b1;
		repeat (2) @(negedge sys_clk);
		sys_rst = 1'b0;
		cnt = 0;
		thr = 6'h08;
		check("fast filter reset", {7'h00, force_fast_input_filter}, 8'h00);
		rreg(`REG_STATUS_TWO, 8'h00);
		rreg(`REG_WARN_LEVEL, 8'h08);
		rreg(`REG_FIFO_LEVEL, 8'h00);
		rreg(`REG_STATUS_ONE, s1());
		repeat (3) @(negedge sys_clk);
		check("reads pending", 8'(exp_q.size()), 8'h00);
		summarize();
	end

endmodule
